// ==== memory_map_decoder.sv ====
// Memory map decoder: program, data, register and configuration space routing
// Function
// - Data space 64kB; beyond on-chip goes external
// - Hardware config registers writable only programming
// - Three-bit select splits flash program/data
// - Zero program flash: all fetches external
// - Program space shrinks from top; above external
// - SRAM 1kB at bottom, data flash above
// - Write-select bit picks flash mapping for data-move
// - Never fetch instructions from data flash
// - Lock blocks program flash erase and write
// - Internal data never driven on port 0
// - Erase in 128-byte pages before writing
// - Config memory readable, never writable, user mode
// - Programming mode: 8070h-8079h stay read-only
// - Config one at 807Eh, zero at 807Fh
// - 16-bit config addresses programming, 8-bit user
// - Direct 0-7Fh scratchpad, 80h-FFh special registers
// - Register space separate: 256 scratchpad, 128 registers
module memory_map_decoder (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic PROG_MODE_I,
  input wire logic FETCH_REQ_I,
  input wire memory_map_pkg::addr_t FETCH_ADDR_I,
  output logic FETCH_INT_O,
  output logic FETCH_EXT_O,
  input wire logic DMOVE_REQ_I,
  input wire logic DMOVE_WE_I,
  input wire memory_map_pkg::addr_t DMOVE_ADDR_I,
  input wire memory_map_pkg::byte_t DMOVE_WDATA_I,
  output logic SEL_SRAM_O,
  output logic SEL_FLASH_O,
  output logic SEL_EXT_O,
  input wire logic ERASE_REQ_I,
  input wire logic [memory_map_pkg::PAGE_W-1:0] ERASE_PAGE_I,
  output logic FLASH_WE_O,
  output logic FLASH_ERASE_O,
  output logic [memory_map_pkg::FIDX_W-1:0] FLASH_ADDR_O,
  output memory_map_pkg::byte_t FLASH_WDATA_O,
  output memory_map_pkg::byte_t P0_O,
  output logic P0_OE_O,
  output memory_map_pkg::byte_t P2_O,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_INDIRECT_I,
  output logic REG_SEL_SCRATCH_O,
  output logic REG_SEL_SPR_O,
  input wire logic SPR_WR_I,
  input wire logic SPR_RD_I,
  input wire logic [7:0] SPR_ADDR_I,
  input wire memory_map_pkg::byte_t SPR_WDATA_I,
  output memory_map_pkg::byte_t SPR_RDATA_O,
  input wire logic PRG_WE_I,
  input wire memory_map_pkg::addr_t PRG_ADDR_I,
  input wire memory_map_pkg::byte_t PRG_WDATA_I,
  output memory_map_pkg::byte_t PRG_RDATA_O,
  output logic [2:0] SPLIT_SEL_O,
  output logic LOCK_O
);
  import memory_map_pkg::*;

  cfg_mem_if cfg ();
  cap_state_t state_ff;
  logic [2:0] split_ff;
  logic lock_ff;
  logic [7:0] wsel_ff;
  logic [CFG_IDX_W-1:0] cfg_addr_ff;
  logic [16:0] pm_bytes;
  logic [16:0] dm_bytes;
  logic [16:0] daddr_x;
  logic [16:0] faddr_x;
  logic [16:0] fetch_x;
  logic wpath;
  logic dm_sram;
  logic dm_flash;
  logic dm_ext;
  logic [16:0] flash_idx;
  logic prg_in_cfg;
  logic prg_ro;
  logic wr_ok;
  logic erase_ok;
  logic [16:0] erase_base;

  cfg_mem_store u_cfg (
    .CLK_I(CLK_I),
    .RST_I(RST_I),
    .cfg(cfg)
  );

  ////////////////////////////////////////////////////////////////////////
  // Partition capture one cycle after reset release
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state_ff <= ST_CAPTURE;
    end else begin
      case (state_ff)
        ST_CAPTURE: state_ff <= ST_RUN;
        ST_RUN: state_ff <= ST_RUN;
        default: state_ff <= ST_CAPTURE;
      endcase
    end
  end

  // Split and lock taken from hw_config_zero
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      split_ff <= SPLIT_DEFAULT;
      lock_ff <= 1'b0;
    end else if (state_ff == ST_CAPTURE) begin
      split_ff <= cfg.hw_config_zero[SPLIT_LSB +: 3];
      lock_ff <= ~cfg.hw_config_zero[LOCK_BIT];
    end
  end

  assign SPLIT_SEL_O = split_ff;
  assign LOCK_O = lock_ff;

  ////////////////////////////////////////////////////////////////////////
  // Boundaries from the captured split
  assign dm_bytes = data_flash_bytes(split_ff);
  assign pm_bytes = prog_flash_bytes(split_ff);
  assign wpath = wsel_ff[WPATH_BIT];

  // Program fetch: internal below program top, else external
  assign fetch_x = {1'b0, FETCH_ADDR_I};
  assign FETCH_INT_O = FETCH_REQ_I && (fetch_x < pm_bytes);
  assign FETCH_EXT_O = FETCH_REQ_I && (fetch_x >= pm_bytes);

  ////////////////////////////////////////////////////////////////////////
  // Data-space decode: SRAM, then flash, then external
  assign daddr_x = {1'b0, DMOVE_ADDR_I};
  assign faddr_x = daddr_x - {1'b0, DFLASH_BASE};
  always_comb begin
    dm_sram = 1'b0;
    dm_flash = 1'b0;
    dm_ext = 1'b0;
    flash_idx = 17'h00000;
    if (DMOVE_REQ_I) begin
      if (DMOVE_ADDR_I < SRAM_BYTES) begin
        dm_sram = 1'b1;
      end else if (wpath && (daddr_x < pm_bytes)) begin
        dm_flash = 1'b1;
        flash_idx = daddr_x;
      end else if (!wpath && (faddr_x < dm_bytes)) begin
        dm_flash = 1'b1;
        flash_idx = pm_bytes + faddr_x;
      end else begin
        dm_ext = 1'b1;
      end
    end
  end

  assign SEL_SRAM_O = dm_sram;
  assign SEL_FLASH_O = dm_flash;
  assign SEL_EXT_O = dm_ext;

  ////////////////////////////////////////////////////////////////////////
  // Flash write and page erase gating by the program lock
  assign wr_ok = dm_flash && DMOVE_WE_I && !(lock_ff && (flash_idx < pm_bytes));
  assign erase_base = {2'b00, ERASE_PAGE_I, 7'h00};
  assign erase_ok = ERASE_REQ_I && !(lock_ff && (erase_base < pm_bytes));

  // Flash command registers
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      FLASH_WE_O <= 1'b0;
      FLASH_ERASE_O <= 1'b0;
      FLASH_ADDR_O <= '0;
      FLASH_WDATA_O <= 8'h00;
    end else begin
      FLASH_WE_O <= wr_ok;
      FLASH_ERASE_O <= erase_ok && !wr_ok;
      if (wr_ok) begin
        FLASH_ADDR_O <= flash_idx[FIDX_W-1:0];
        FLASH_WDATA_O <= DMOVE_WDATA_I;
      end else if (erase_ok) begin
        FLASH_ADDR_O <= erase_base[FIDX_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // External ports: data access wins over fetch; internal stays off port 0
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      P0_O <= 8'h00;
      P0_OE_O <= 1'b0;
      P2_O <= 8'h00;
    end else if (dm_ext) begin
      P2_O <= DMOVE_ADDR_I[15:8];
      P0_O <= DMOVE_WE_I ? DMOVE_WDATA_I : DMOVE_ADDR_I[7:0];
      P0_OE_O <= 1'b1;
    end else if (!DMOVE_REQ_I && FETCH_EXT_O) begin
      P2_O <= FETCH_ADDR_I[15:8];
      P0_O <= FETCH_ADDR_I[7:0];
      P0_OE_O <= 1'b1;
    end else begin
      P0_O <= 8'h00;
      P0_OE_O <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register space: direct upper half is special registers
  assign REG_SEL_SCRATCH_O = REG_INDIRECT_I || (REG_ADDR_I < SPECIAL_BASE);
  assign REG_SEL_SPR_O = !REG_INDIRECT_I && (REG_ADDR_I >= SPECIAL_BASE);

  ////////////////////////////////////////////////////////////////////////
  // Special-function registers owned by this block
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      wsel_ff <= WSEL_RESET;
    end else if (SPR_WR_I && (SPR_ADDR_I == WSEL_OFFSET)) begin
      wsel_ff <= SPR_WDATA_I;
    end
  end

  // 8-bit configuration address in user mode
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      cfg_addr_ff <= CFG_ADDR_RESET[CFG_IDX_W-1:0];
    end else if (SPR_WR_I && (SPR_ADDR_I == CFG_ADDR_OFFSET)) begin
      cfg_addr_ff <= SPR_WDATA_I[CFG_IDX_W-1:0];
    end
  end

  // Register read data
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      SPR_RDATA_O <= 8'h00;
    end else if (SPR_RD_I) begin
      case (SPR_ADDR_I)
        WSEL_OFFSET: SPR_RDATA_O <= wsel_ff;
        CFG_ADDR_OFFSET: SPR_RDATA_O <= {1'b0, cfg_addr_ff};
        CFG_DATA_OFFSET: SPR_RDATA_O <= cfg.user_data;
        default: SPR_RDATA_O <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration memory: 16-bit programming port, writes gated by mode
  assign prg_in_cfg = (PRG_ADDR_I >= CFG_PRG_BASE) &&
                      (PRG_ADDR_I < (CFG_PRG_BASE + 16'(CFG_BYTES)));
  assign prg_ro = (PRG_ADDR_I >= CFG_RO_LOW) && (PRG_ADDR_I <= CFG_RO_HIGH);
  assign cfg.user_idx = cfg_addr_ff;
  assign cfg.prg_idx = PRG_ADDR_I[CFG_IDX_W-1:0];
  assign cfg.wr_en = PROG_MODE_I && PRG_WE_I && prg_in_cfg && !prg_ro;
  assign cfg.wr_data = PRG_WDATA_I;

  // Programming read data, zero outside programming mode
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      PRG_RDATA_O <= 8'h00;
    end else begin
      PRG_RDATA_O <= (PROG_MODE_I && prg_in_cfg) ? cfg.prg_data : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  sequence ext_data_s;
    DMOVE_REQ_I && (DMOVE_ADDR_I >= SRAM_BYTES) && !SEL_FLASH_O;
  endsequence

  sequence int_data_s;
    DMOVE_REQ_I && (SEL_SRAM_O || SEL_FLASH_O);
  endsequence

  sram_low_a: assert property (DMOVE_REQ_I && (DMOVE_ADDR_I < 16'h0400) |-> SEL_SRAM_O && !SEL_EXT_O)
    else $error("low data address not served by SRAM");
  ext_route_a: assert property (ext_data_s |-> SEL_EXT_O ##1 (P0_OE_O && P2_O == $past(DMOVE_ADDR_I[15:8])))
    else $error("external data access not driven on ports");
  p0_quiet_a: assert property (int_data_s |=> !P0_OE_O && P0_O == 8'h00)
    else $error("internal data access seen on port 0");
  fetch_split_a: assert property (FETCH_REQ_I && ({1'b0, FETCH_ADDR_I} >= pm_bytes) |-> FETCH_EXT_O && !FETCH_INT_O)
    else $error("fetch above program top not external");
  fetch_zero_a: assert property (FETCH_REQ_I && pm_bytes == 17'h00000 |-> !FETCH_INT_O)
    else $error("fetch internal with zero program flash");
  no_dflash_exec_a: assert property (FETCH_INT_O |-> {1'b0, FETCH_ADDR_I} < (17'h08000 - dm_bytes))
    else $error("fetch reached data flash");
  dflash_base_a: assert property (DMOVE_REQ_I && !wpath && dm_bytes != 0 && DMOVE_ADDR_I == 16'h0400
                                 |-> SEL_FLASH_O && flash_idx == pm_bytes)
    else $error("data flash does not start above SRAM");
  lock_block_a: assert property (lock_ff && DMOVE_WE_I && SEL_FLASH_O && flash_idx < pm_bytes |=> !FLASH_WE_O)
    else $error("locked program flash written");
  cfg_user_ro_a: assert property (!PROG_MODE_I |=> $stable(cfg.hw_config_zero) && $stable(cfg.hw_config_one))
    else $error("configuration changed in user mode");
  cfg_ro_window_a: assert property (PRG_WE_I && PRG_ADDR_I[15:4] == 12'h807 && PRG_ADDR_I[3:0] <= 4'h9
                                    |-> !cfg.wr_en)
    else $error("read-only configuration location written");
  reg_space_a: assert property (!REG_INDIRECT_I && REG_ADDR_I[7] |-> REG_SEL_SPR_O && !REG_SEL_SCRATCH_O)
    else $error("direct upper address not special register");
  capture_a: assert property ($fell(state_ff == ST_CAPTURE) |-> split_ff == $past(cfg.hw_config_zero[2:0]))
    else $error("partition not captured after reset");

endmodule

// ==== memory_map_pkg.sv ====
// Constants, types and decode functions for the memory map decoder
package memory_map_pkg;

  // Address and data widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int FIDX_W = 15;
  localparam int PAGE_W = 8;
  localparam int CFG_IDX_W = 7;

  // Memory sizes
  localparam logic [16:0] FLASH_BYTES = 17'h08000;
  localparam logic [15:0] SRAM_BYTES = 16'h0400;
  localparam logic [15:0] DFLASH_BASE = 16'h0400;
  localparam int CFG_BYTES = 128;
  localparam int PAGE_BYTES = 128;

  // Register space decode
  localparam logic [7:0] SPECIAL_BASE = 8'h80;

  // Special-function register offsets
  localparam logic [7:0] WSEL_OFFSET = 8'h8F;
  localparam logic [7:0] CFG_ADDR_OFFSET = 8'h93;
  localparam logic [7:0] CFG_DATA_OFFSET = 8'h94;
  localparam int WPATH_BIT = 0;
  localparam logic [7:0] WSEL_RESET = 8'h00;
  localparam logic [7:0] CFG_ADDR_RESET = 8'h00;

  // Configuration memory map in programming mode
  localparam logic [15:0] CFG_PRG_BASE = 16'h8000;
  localparam logic [15:0] CFG_RO_LOW = 16'h8070;
  localparam logic [15:0] CFG_RO_HIGH = 16'h8079;
  localparam logic [15:0] HW_CONFIG_ONE_ADDR = 16'h807E;
  localparam logic [15:0] HW_CONFIG_ZERO_ADDR = 16'h807F;
  localparam logic [CFG_IDX_W-1:0] HW_CONFIG_ONE_IDX = 7'h7E;
  localparam logic [CFG_IDX_W-1:0] HW_CONFIG_ZERO_IDX = 7'h7F;
  localparam logic [DATA_W-1:0] CFG_RESET = 8'hFF;

  // Fields of hw_config_zero
  localparam int SPLIT_LSB = 0;
  localparam int LOCK_BIT = 4;
  localparam logic [2:0] SPLIT_DEFAULT = 3'h7;

  // Reset capture sequencing
  typedef enum logic [1:0] {
    ST_CAPTURE = 2'h1,
    ST_RUN = 2'h2
  } cap_state_t;

  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [DATA_W-1:0] byte_t;

  // Data flash bytes for a partition select, capped at the part size
  function automatic logic [16:0] data_flash_bytes(input logic [2:0] sel);
    logic [16:0] want;
    want = 17'h00000;
    case (sel)
      3'h0, 3'h1: want = FLASH_BYTES;
      3'h2: want = 17'h04000;
      3'h3: want = 17'h02000;
      3'h4: want = 17'h01000;
      3'h5: want = 17'h00800;
      3'h6: want = 17'h00400;
      default: want = 17'h00000;
    endcase
    return (want > FLASH_BYTES) ? FLASH_BYTES : want;
  endfunction

  // Program flash bytes left for a partition select
  function automatic logic [16:0] prog_flash_bytes(input logic [2:0] sel);
    return FLASH_BYTES - data_flash_bytes(sel);
  endfunction

endpackage

// ==== cfg_mem_if.sv ====
// Carrier between decoder and configuration memory store
interface cfg_mem_if;
  import memory_map_pkg::*;
  logic [CFG_IDX_W-1:0] user_idx;
  logic [DATA_W-1:0] user_data;
  logic [CFG_IDX_W-1:0] prg_idx;
  logic [DATA_W-1:0] prg_data;
  logic wr_en;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W-1:0] hw_config_zero;
  logic [DATA_W-1:0] hw_config_one;
  modport store(input user_idx, prg_idx, wr_en, wr_data,
                output user_data, prg_data, hw_config_zero, hw_config_one);
  modport user(output user_idx, prg_idx, wr_en, wr_data,
               input user_data, prg_data, hw_config_zero, hw_config_one);
endinterface

// ==== cfg_mem_store.sv ====
// Configuration memory: 128 bytes of flip-flops with two read ports
module cfg_mem_store (
  input wire logic CLK_I,
  input wire logic RST_I,
  cfg_mem_if.store cfg
);
  import memory_map_pkg::*;

  logic [DATA_W-1:0] mem_ff [CFG_BYTES] = '{default: CFG_RESET};

  ////////////////////////////////////////////////////////////////////////
  // Storage cells, erased at power-up and kept across reset so the split survives it
  for (genvar i = 0; i < CFG_BYTES; i++) begin : g_cell
    always_ff @(posedge CLK_I) begin
      if (!RST_I && cfg.wr_en && (cfg.prg_idx == CFG_IDX_W'(i))) begin
        mem_ff[i] <= cfg.wr_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read ports and fixed configuration words
  assign cfg.user_data = mem_ff[cfg.user_idx];
  assign cfg.prg_data = mem_ff[cfg.prg_idx];
  assign cfg.hw_config_zero = mem_ff[HW_CONFIG_ZERO_IDX];
  assign cfg.hw_config_one = mem_ff[HW_CONFIG_ONE_IDX];

endmodule

// ==== cpu_core_model.sv ====
// Processor core model raising fetch, data-move and page erase requests
module cpu_core_model (
  input wire logic clk_i,
  output logic freq_o,
  output memory_map_pkg::addr_t faddr_o,
  output logic dreq_o,
  output logic dwe_o,
  output memory_map_pkg::addr_t daddr_o,
  output memory_map_pkg::byte_t dwdata_o,
  output logic ereq_o,
  output logic [7:0] epage_o
);
  import memory_map_pkg::*;
  ////////////////////////////////////////////////////////////
  // Idle at time zero
  initial begin
    {freq_o, dreq_o, dwe_o, ereq_o} = 4'h0;
    {faddr_o, daddr_o, dwdata_o, epage_o} = 48'h0;
  end
  // One request per cycle: 0 fetch, 1 data move, 2 erase
  task automatic issue(input int k, input logic we, input addr_t a, input byte_t d);
    @(negedge clk_i);
    freq_o = (k == 0);
    dreq_o = (k == 1);
    ereq_o = (k == 2);
    dwe_o = we;
    faddr_o = a;
    daddr_o = a;
    dwdata_o = d;
    epage_o = a[7:0]; // Whole page number
  endtask
  // Request lines drop to zero; address, data, write and page lines show the inverse of the last value
  task automatic drop();
    @(negedge clk_i);
    {freq_o, dreq_o, ereq_o} = 3'h0;
    dwe_o = ~dwe_o;
    faddr_o = ~faddr_o;
    daddr_o = ~daddr_o;
    dwdata_o = ~dwdata_o;
    epage_o = ~epage_o;
  endtask
endmodule

// ==== memory_map_decoder_test.sv ====
// Self-checking bench for the memory map decoder
module memory_map_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  import memory_map_pkg::*;
  logic clk, rst, prog_mode, spr_wr, spr_rd, prg_we, reg_ind, fint, fext, s_sram, s_flash, s_ext;
  logic freq, dreq, dwe, ereq, fl_we, fl_er, p0_oe, r_scr, r_spr, lock;
  addr_t faddr, daddr, prg_addr;
  byte_t dwdata, spr_wdata, spr_rdata, prg_wdata, prg_rdata, fl_wdata, p0, p2, rd;
  logic [7:0] epage, spr_addr, reg_addr;
  logic [14:0] fl_addr;
  logic [2:0] split;
  int error_cnt = 0;
  int samples_checked = 0;
  int pm_kb[8] = '{0, 0, 16, 24, 28, 30, 31, 32};
  ////////////////////////////////////////////////////////////
  cpu_core_model cpu_u (.clk_i(clk), .freq_o(freq), .faddr_o(faddr), .dreq_o(dreq), .dwe_o(dwe),
    .daddr_o(daddr), .dwdata_o(dwdata), .ereq_o(ereq), .epage_o(epage));
  memory_map_decoder dut_u (.CLK_I(clk), .RST_I(rst), .PROG_MODE_I(prog_mode), .FETCH_REQ_I(freq),
    .FETCH_ADDR_I(faddr),
    .FETCH_INT_O(fint), .FETCH_EXT_O(fext), .DMOVE_REQ_I(dreq), .DMOVE_WE_I(dwe), .DMOVE_ADDR_I(daddr),
    .DMOVE_WDATA_I(dwdata), .SEL_SRAM_O(s_sram), .SEL_FLASH_O(s_flash), .SEL_EXT_O(s_ext),
    .ERASE_REQ_I(ereq), .ERASE_PAGE_I(epage), .FLASH_WE_O(fl_we), .FLASH_ERASE_O(fl_er),
    .FLASH_ADDR_O(fl_addr), .FLASH_WDATA_O(fl_wdata), .P0_O(p0), .P0_OE_O(p0_oe), .P2_O(p2),
    .REG_ADDR_I(reg_addr), .REG_INDIRECT_I(reg_ind), .REG_SEL_SCRATCH_O(r_scr), .REG_SEL_SPR_O(r_spr),
    .SPR_WR_I(spr_wr), .SPR_RD_I(spr_rd), .SPR_ADDR_I(spr_addr), .SPR_WDATA_I(spr_wdata),
    .SPR_RDATA_O(spr_rdata), .PRG_WE_I(prg_we), .PRG_ADDR_I(prg_addr), .PRG_WDATA_I(prg_wdata),
    .PRG_RDATA_O(prg_rdata), .SPLIT_SEL_O(split), .LOCK_O(lock));
  ////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic close_out();
    $display("Checks %0d, errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Register strobes, one cycle each
  task automatic spr_write(input logic [7:0] a, input byte_t d);
    @(negedge clk);
    spr_wr = 1'b1;
    spr_addr = a;
    spr_wdata = d;
    @(negedge clk);
    spr_wr = 1'b0;
    spr_wdata = ~d;
  endtask
  task automatic spr_read(input logic [7:0] a, output byte_t d);
    @(negedge clk);
    spr_rd = 1'b1;
    spr_addr = a;
    @(negedge clk);
    spr_rd = 1'b0;
    d = spr_rdata;
  endtask
  // Programming port accesses
  task automatic cfg_write(input addr_t a, input byte_t d);
    @(negedge clk);
    prg_we = 1'b1;
    prg_addr = a;
    prg_wdata = d;
    @(negedge clk);
    prg_we = 1'b0;
    prg_wdata = ~d;
  endtask
  task automatic cfg_read(input addr_t a, output byte_t d);
    @(negedge clk);
    prg_addr = a;
    @(negedge clk);
    d = prg_rdata;
  endtask
  // Program hw_config_zero, then reset so it is captured
  task automatic load_split(input byte_t v);
    @(negedge clk);
    prog_mode = 1'b1;
    cfg_write(16'h807F, v);
    cfg_read(16'h807F, rd);
    check(rd, v);
    prog_mode = 1'b0;
    rst = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  // One request: decode seen live, port enable seen after
  task automatic probe(input int k, input logic we, input addr_t a, input byte_t d, input logic [2:0] exp);
    cpu_u.issue(k, we, a, d);
    #1;
    if (k == 0) check({fint, fext}, exp[1:0]);
    if (k == 1) check({s_sram, s_flash, s_ext}, exp);
    cpu_u.drop();
    #1;
    if (k == 1) check(p0_oe, exp[0]);
    if (k < 2 && exp[0]) check(p2, a[15:8]);
    if (k == 1 && !exp[0]) check(p0, 8'h00);
  endtask
  // Reset state and write select register
  task automatic t_reset_values();
    check(split, 3'h7);
    check(lock, 1'b0);
    spr_read(WSEL_OFFSET, rd);
    check(rd, WSEL_RESET);
    spr_write(WSEL_OFFSET, 8'h01);
    spr_read(WSEL_OFFSET, rd);
    check(rd, 8'h01);
    spr_read(8'hA5, rd);
    check(rd, 8'h00);
  endtask
  // Register space selects
  task automatic reg_probe(input logic ind, input logic [7:0] a, input logic [1:0] exp);
    @(negedge clk);
    reg_ind = ind;
    reg_addr = a;
    #1;
    check({r_scr, r_spr}, exp);
  endtask
  task automatic t_reg_space();
    reg_probe(1'b0, 8'h7F, 2'h2);
    reg_probe(1'b0, 8'h80, 2'h1);
    reg_probe(1'b1, 8'h80, 2'h2);
    reg_probe(1'b1, 8'hFF, 2'h2);
  endtask
  // Configuration memory protection in both modes
  task automatic t_config_mem();
    @(negedge clk);
    prog_mode = 1'b1;
    cfg_write(16'h8070, 8'h00);
    cfg_read(16'h8070, rd);
    check(rd, 8'hFF);
    cfg_write(16'h8079, 8'h00);
    cfg_read(16'h8079, rd);
    check(rd, 8'hFF);
    cfg_write(16'h806F, 8'h3C);
    cfg_read(16'h806F, rd);
    check(rd, 8'h3C);
    cfg_write(16'h807E, 8'h5A);
    @(negedge clk);
    prog_mode = 1'b0;
    cfg_write(16'h807E, 8'hA5);
    spr_write(CFG_ADDR_OFFSET, 8'h7E);
    spr_read(CFG_DATA_OFFSET, rd);
    check(rd, 8'h5A);
    cfg_read(16'h807E, rd);
    check(rd, 8'h00);
  endtask
  // Every partition code: fetch and data boundaries
  task automatic t_split_table();
    addr_t pm;
    addr_t dm;
    for (int s = 0; s < 8; s++) begin
      pm = 16'(pm_kb[s] * 1024);
      dm = 16'h8000 - pm;
      load_split(8'hF8 | 8'(s));
      check(split, s[2:0]);
      if (pm == 16'h0) probe(0, 1'b0, 16'h0000, 8'h00, 3'h1);
      else probe(0, 1'b0, pm - 16'h1, 8'h00, 3'h2);
      probe(0, 1'b0, pm, 8'h00, 3'h1);
      probe(1, 1'b0, 16'h03FF, 8'h00, 3'h4);
      probe(1, 1'b0, 16'h0400 + dm, 8'h00, 3'h1);
      if (dm != 16'h0) begin
        probe(1, 1'b1, 16'h03FF + dm, 8'hC3, 3'h2);
        check({fl_we, fl_addr, fl_wdata}, {1'b1, 15'(pm + dm - 16'h1), 8'hC3});
      end
    end
  endtask
  // Write path bit and program lock
  task automatic t_lock();
    load_split(8'hF6);
    spr_write(WSEL_OFFSET, 8'h01);
    probe(1, 1'b1, 16'h0500, 8'h11, 3'h2);
    check({fl_we, fl_addr}, {1'b1, 15'h0500});
    load_split(8'hE6);
    check(lock, 1'b1);
    spr_write(WSEL_OFFSET, 8'h01);
    probe(1, 1'b1, 16'h0500, 8'h11, 3'h2);
    check(fl_we, 1'b0);
    spr_write(WSEL_OFFSET, 8'h00);
    probe(1, 1'b1, 16'h0400, 8'h22, 3'h2);
    check({fl_we, fl_addr, fl_wdata}, {1'b1, 15'h7C00, 8'h22});
    probe(2, 1'b0, 16'h00F8, 8'h00, 3'h0);
    check({fl_er, fl_addr}, {1'b1, 15'h7C00});
    probe(2, 1'b0, 16'h0000, 8'h00, 3'h0);
    check(fl_er, 1'b0);
  endtask
  // Hang guard
  initial begin
    #200us;
    error_cnt++;
    close_out();
  end
  // Main sequence
  initial begin
    {rst, prog_mode, spr_wr, spr_rd, prg_we, reg_ind} = 6'h20;
    {spr_addr, spr_wdata, reg_addr, prg_wdata} = 32'h0;
    prg_addr = 16'h0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    t_reset_values();
    t_reg_space();
    t_config_mem();
    t_split_table();
    t_lock();
    close_out();
  end
endmodule
